// file: rtl/ata_xlate_pkg.sv
package ata_xlate_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GEOM = 8'h04;
    localparam logic [7:0] OFS_TASK = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_LBA = 8'h14;
    localparam logic [7:0] OFS_PHYS = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_IDENT_CYL = 8'h24;
    localparam logic [7:0] OFS_DEFECT = 8'h28;
    // Control register fields
    localparam int CTRL_CSEL_EN = 0;
    localparam int CTRL_WCACHE = 1;
    localparam int CTRL_RAHEAD = 2;
    localparam int CTRL_MULTI = 3;
    localparam int CTRL_BLK_LO = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0106;
    // Interrupt event bits
    localparam int EV_DONE = 0;
    localparam int EV_BLOCK = 1;
    localparam int EV_ADDR_ERR = 2;
    localparam int EV_GEOM_REJ = 3;
    localparam int EV_N = 4;
    // Command codes
    localparam logic [1:0] CMD_READ = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    // Power-up translated geometry
    localparam logic [7:0] DEF_SPT = 8'h3f;
    localparam logic [15:0] IDENT_LIMIT_CYL = 16'h0ffc;
    localparam logic [7:0] SECTOR_BASE = 8'h01;
    // Task file as latched from the shared cable
    typedef struct packed {
        logic [2:0] spare;
        logic dev;
        logic [3:0] head;
        logic [15:0] cyl;
        logic [7:0] sector;
    } task_file_t;
    // Host-chosen translated geometry
    typedef struct packed {
        logic [7:0] spt;
        logic [2:0] spare;
        logic [4:0] heads;
        logic [15:0] cyl;
    } geom_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_WAIT_STACK = 3'b010,
        ST_FILL = 3'b011,
        ST_XFER = 3'b100,
        ST_MEDIA = 3'b101
    } cmd_state_t;
endpackage

// file: rtl/ata_address_translate_select.sv
`timescale 1ns/1ps
module ata_address_translate_select
    import ata_xlate_pkg::*;
#(
    parameter logic [31:0] CAPACITY = 32'h00fa_5ea0,
    parameter logic [15:0] DEF_CYL = 16'h3f96,
    parameter logic [4:0] DEF_HEADS = 5'h10,
    parameter int STACK_DEPTH = 4,
    parameter int DEF_N = 4,
    parameter logic [7:0] RA_MAX = 8'h80
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Jumper and cable pins
    input wire logic master_slave_jumper,
    input wire logic csel,
    input wire logic cylinder_limit_jumper,
    input wire logic host_io_read,
    // Transfer and media events, same clock
    input wire logic host_sector_done,
    input wire logic media_sector_read,
    input wire logic media_write_done,
    input wire logic buffer_full,
    // Outputs to data path and media
    output logic data_bus_oe,
    output logic media_go,
    output logic media_is_write,
    output logic [31:0] media_phys,
    output logic host_xfer_go,
    output logic device_id,
    output logic irq
);
    localparam int SW = $clog2(STACK_DEPTH + 1);

    // Synchronisers for pins
    logic [1:0] ms_sync, cs_sync, lim_sync, rd_sync;
    logic [31:0] ctrl;
    geom_t geom;
    task_file_t task_f;
    logic [15:0] cmd_reg;
    logic [EV_N-1:0] irq_stat, irq_mask, ev_set;
    logic [31:0] defect [DEF_N];
    logic [31:0] lba, lba_calc, phys_calc;
    logic [SW-1:0] stack_cnt;
    logic [31:0] ra_start;
    logic [7:0] ra_fill;
    logic ra_active;
    cmd_state_t state;
    logic [8:0] remain;
    logic [7:0] blk_cnt;
    logic [1:0] cur_cmd;
    // AHB address phase capture
    logic dp_write;
    logic [7:0] dp_addr;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic selected, range_ok, ra_hit, stack_full, cmd_strobe;
    logic [31:0] geom_prod;
    logic [7:0] blk_size;

    // Two flops per pin; only stage one feeds stage two
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_sync <= 2'h0;
            cs_sync <= 2'h0;
            lim_sync <= 2'h0;
            rd_sync <= 2'h0;
        end else begin
            ms_sync <= {ms_sync[0], master_slave_jumper};
            cs_sync <= {cs_sync[0], csel};
            lim_sync <= {lim_sync[0], cylinder_limit_jumper};
            rd_sync <= {rd_sync[0], host_io_read};
        end
    end

    // Jumper high means closed; CSEL low means grounded
    always_comb begin
        if (ctrl[CTRL_CSEL_EN]) begin
            device_id = cs_sync[1];
        end else begin
            device_id = !ms_sync[1];
        end
    end

    // Each drive judges the latched select bit against its own address
    assign selected = (task_f.dev == device_id);
    // Bus drivers stay released unless this drive is the one addressed
    assign data_bus_oe = selected && rd_sync[1];

    // Translation from host CHS to LBA
    always_comb begin
        lba_calc = 32'(task_f.sector) - 32'(SECTOR_BASE)
            + 32'(geom.spt) * (32'(task_f.head)
            + 32'(geom.heads) * 32'(task_f.cyl));
        range_ok = (task_f.sector != 8'h00)
            && (lba_calc < CAPACITY);
    end

    // Push-down over a sorted defect list; each hit shifts one sector on
    always_comb begin
        phys_calc = lba_calc;
        for (int i = 0; i < DEF_N; i++) begin
            if (defect[i][31] && ({1'b0, defect[i][30:0]} <= phys_calc)) begin
                phys_calc = phys_calc + 32'h1;
            end
        end
    end

    // Geometry product for the acceptance check
    assign geom_prod = 32'(hwdata[31:24]) * 32'(hwdata[20:16])
        * 32'(hwdata[15:0]);
    assign stack_full = (stack_cnt == SW'(STACK_DEPTH)) || buffer_full;
    assign ra_hit = ra_active && ctrl[CTRL_RAHEAD] && (lba_calc >= ra_start)
        && (lba_calc < ra_start + 32'(ra_fill));
    assign blk_size = ctrl[CTRL_MULTI] ? ctrl[CTRL_BLK_LO +: 8] : 8'h01;
    assign cmd_strobe = dp_write && (dp_addr == OFS_CMD);

    // Zero-wait slave; OKAY on every access
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && htrans[1] && hready;

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= addr_ok && hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // Read decode; unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            OFS_CTRL: rd_mux = ctrl;
            OFS_GEOM: rd_mux = geom;
            OFS_TASK: rd_mux = task_f;
            OFS_CMD: rd_mux = {16'h0, cmd_reg};
            OFS_STATUS: rd_mux = {16'h0, 8'(stack_cnt), 3'h0, ra_active,
                stack_full, device_id, selected, state != ST_IDLE};
            OFS_LBA: rd_mux = lba;
            OFS_PHYS: rd_mux = media_phys;
            OFS_IRQ_STAT: rd_mux = 32'(irq_stat);
            OFS_IRQ_MASK: rd_mux = 32'(irq_mask);
            OFS_IDENT_CYL: begin
                // Full capacity stays usable; only the report is capped
                rd_mux = {16'h0, lim_sync[1] ? IDENT_LIMIT_CYL
                    : geom.cyl};
            end
            default: begin
                for (int i = 0; i < DEF_N; i++) begin
                    if (haddr[7:0] == OFS_DEFECT + 8'(4 * i)) begin
                        rd_mux = defect[i];
                    end
                end
            end
        endcase
    end

    // Read data registered during the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // Control, task file and command registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RESET;
            task_f <= '0;
            cmd_reg <= 16'h0;
            irq_mask <= '0;
        end else if (dp_write) begin
            case (dp_addr)
                OFS_CTRL: ctrl <= hwdata;
                OFS_TASK: task_f <= hwdata;
                OFS_CMD: cmd_reg <= hwdata[15:0];
                OFS_IRQ_MASK: irq_mask <= hwdata[EV_N-1:0];
                default: ;
            endcase
        end
    end

    // Geometry: a product above capacity is refused and flagged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            geom <= '{spt: DEF_SPT, spare: 3'h0, heads: DEF_HEADS,
                cyl: DEF_CYL};
        end else if (dp_write && dp_addr == OFS_GEOM
                && geom_prod <= CAPACITY) begin
            geom <= hwdata;
        end
    end

    // Defect list, kept sorted by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < DEF_N; i++) begin
                defect[i] <= 32'h0;
            end
        end else if (dp_write) begin
            for (int i = 0; i < DEF_N; i++) begin
                if (dp_addr == OFS_DEFECT + 8'(4 * i)) begin
                    defect[i] <= hwdata;
                end
            end
        end
    end

    // Command sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            cur_cmd <= 2'h0;
            remain <= 9'h0;
            blk_cnt <= 8'h0;
            lba <= 32'h0;
            media_phys <= 32'h0;
            media_go <= 1'b0;
            media_is_write <= 1'b0;
            host_xfer_go <= 1'b0;
        end else begin
            media_go <= 1'b0;
            host_xfer_go <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Unselected drive ignores the command
                    if (cmd_strobe && selected
                            && (hwdata[1:0] == CMD_READ
                            || hwdata[1:0] == CMD_WRITE)) begin
                        cur_cmd <= hwdata[1:0];
                        remain <= {hwdata[15:8] == 8'h00, hwdata[15:8]};
                        blk_cnt <= 8'h0;
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    lba <= lba_calc;
                    if (!range_ok) begin
                        state <= ST_IDLE;
                    end else if (cur_cmd == CMD_WRITE) begin
                        media_phys <= phys_calc;
                        if (ctrl[CTRL_WCACHE] && stack_full) begin
                            state <= ST_WAIT_STACK;
                        end else begin
                            host_xfer_go <= 1'b1;
                            state <= ST_XFER;
                        end
                    end else if (ra_hit) begin
                        host_xfer_go <= 1'b1;
                        state <= ST_XFER;
                    end else begin
                        media_phys <= phys_calc;
                        media_go <= 1'b1;
                        media_is_write <= 1'b0;
                        state <= ST_FILL;
                    end
                end
                ST_WAIT_STACK: begin
                    if (!stack_full) begin
                        host_xfer_go <= 1'b1;
                        state <= ST_XFER;
                    end
                end
                ST_FILL: begin
                    // First sector in the buffer releases the host
                    if (ra_fill != 8'h00) begin
                        host_xfer_go <= 1'b1;
                        state <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (host_sector_done) begin
                        remain <= remain - 9'h1;
                        blk_cnt <= (blk_cnt + 8'h1 == blk_size) ? 8'h0
                            : blk_cnt + 8'h1;
                        if (remain == 9'h1) begin
                            if (cur_cmd == CMD_WRITE) begin
                                media_go <= 1'b1;
                                media_is_write <= 1'b1;
                            end
                            // Uncached writes wait for the media
                            if (cur_cmd == CMD_WRITE
                                    && !ctrl[CTRL_WCACHE]) begin
                                state <= ST_MEDIA;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_MEDIA: begin
                    if (media_write_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Events feeding the sticky status
    always_comb begin
        ev_set = '0;
        ev_set[EV_ADDR_ERR] = (state == ST_CHECK) && !range_ok;
        ev_set[EV_GEOM_REJ] = dp_write && dp_addr == OFS_GEOM
            && geom_prod > CAPACITY;
        ev_set[EV_DONE] = ((state == ST_XFER) && host_sector_done
            && remain == 9'h1 && !(cur_cmd == CMD_WRITE
            && !ctrl[CTRL_WCACHE]))
            || ((state == ST_MEDIA) && media_write_done);
        // Block end only, and not on the final sector
        ev_set[EV_BLOCK] = (state == ST_XFER) && host_sector_done
            && remain != 9'h1 && (blk_cnt + 8'h1 == blk_size);
    end

    // Write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else if (dp_write && dp_addr == OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~hwdata[EV_N-1:0]) | ev_set;
        end else begin
            irq_stat <= irq_stat | ev_set;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Cached write stack; media completions free an entry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_cnt <= '0;
        end else begin
            case ({ev_set[EV_DONE] && cur_cmd == CMD_WRITE
                    && ctrl[CTRL_WCACHE] && state == ST_XFER,
                    media_write_done && stack_cnt != '0})
                2'b10: stack_cnt <= stack_cnt + SW'(1);
                2'b01: stack_cnt <= stack_cnt - SW'(1);
                default: ;
            endcase
        end
    end

    // Read-ahead window; a hit leaves it running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ra_active <= 1'b0;
            ra_start <= 32'h0;
            ra_fill <= 8'h0;
        end else if (state == ST_CHECK && range_ok && cur_cmd == CMD_READ
                && !ra_hit) begin
            ra_active <= 1'b1;
            ra_start <= lba_calc;
            ra_fill <= 8'h0;
        end else if (state == ST_CHECK && range_ok
                && cur_cmd == CMD_WRITE) begin
            // Writes may overlap buffered read data, so drop it
            ra_active <= 1'b0;
        end else if (ra_active && media_sector_read && ra_fill < RA_MAX) begin
            ra_fill <= ra_fill + 8'h1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    lba_formula_a: assert property (state == ST_CHECK |=> lba == $past(
        32'(task_f.sector) - 32'h1 + 32'(geom.spt) * (32'(task_f.head)
        + 32'(geom.heads) * 32'(task_f.cyl))))
        else $error("lba not formed from chs");
    range_gate_a: assert property (state == ST_CHECK && !range_ok
        |=> state == ST_IDLE && irq_stat[EV_ADDR_ERR])
        else $error("out of range access not aborted");
    no_media_bad_a: assert property (media_go && !media_is_write
        |-> $past(range_ok))
        else $error("media started on bad lba");
    unsel_idle_a: assert property (state == ST_IDLE && !selected
        |=> state == ST_IDLE)
        else $error("unselected drive took a command");
    bus_release_a: assert property (!selected |-> !data_bus_oe)
        else $error("unselected drive drives bus");
    id_pick_a: assert property (!ctrl[CTRL_CSEL_EN] && $stable(ms_sync[1])
        |-> device_id == !ms_sync[1])
        else $error("jumper identity wrong");
    csel_pick_a: assert property (ctrl[CTRL_CSEL_EN]
        |-> device_id == cs_sync[1])
        else $error("cable select identity wrong");
    hit_start_a: assert property (state == ST_CHECK && cur_cmd == CMD_READ
        && range_ok && ra_hit |=> host_xfer_go && ra_active)
        else $error("read-ahead hit did not start host");
    cache_done_a: assert property (state == ST_XFER && host_sector_done
        && remain == 9'h1 && ctrl[CTRL_WCACHE]
        |=> irq_stat[EV_DONE] ##1 state != ST_MEDIA)
        else $error("cached write did not complete");
    stack_cap_a: assert property (stack_cnt <= SW'(STACK_DEPTH))
        else $error("write stack overflow");
endmodule

// file: test/host_adapter_model.sv
`timescale 1ns/1ps
module host_adapter_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Transfer start from the drive, sector count of the command
    input wire logic host_xfer_go,
    input wire logic [8:0] sectors,
    // Sector strobe towards the drive
    output logic host_sector_done
);
    logic [8:0] left;
    logic [1:0] gap;

    // One sector every fourth cycle; the slow pace lets any interrupt
    // raised between sectors show before the next one moves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left <= 9'h000;
            gap <= 2'h0;
            host_sector_done <= 1'b0;
        end else begin
            host_sector_done <= 1'b0;
            gap <= gap + 2'h1;
            if (host_xfer_go && left == 9'h000) begin
                left <= sectors; // Loaded once per command
            end else if (left != 9'h000 && gap == 2'h3) begin
                left <= left - 9'h001;
                host_sector_done <= 1'b1;
            end
        end
    end
endmodule

// file: test/tb_ata_address_translate_select.sv
`timescale 1ns/1ps
module tb_ata_address_translate_select;
    import ata_xlate_pkg::*;
    typedef struct packed {logic [7:0] ofs; logic [31:0] exp;} row_t;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, media_phys;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic master_slave_jumper, csel, cylinder_limit_jumper, host_io_read;
    logic host_sector_done, media_sector_read, media_write_done;
    logic buffer_full, data_bus_oe, media_go, media_is_write;
    logic host_xfer_go, device_id, irq;
    logic [8:0] nsec;
    int err_total, check_count, sec_seen, go_count, wr_count, first_irq;
    row_t rows [5];
    logic [31:0] tf [3];
    logic [31:0] st [3];

    ata_address_translate_select ata_address_translate_select_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .master_slave_jumper(master_slave_jumper),
        .csel(csel), .cylinder_limit_jumper(cylinder_limit_jumper),
        .host_io_read(host_io_read), .host_sector_done(host_sector_done),
        .media_sector_read(media_sector_read),
        .media_write_done(media_write_done), .buffer_full(buffer_full),
        .data_bus_oe(data_bus_oe), .media_go(media_go),
        .media_is_write(media_is_write), .media_phys(media_phys),
        .host_xfer_go(host_xfer_go), .device_id(device_id), .irq(irq));
    host_adapter_model host_adapter_model_i (
        .hclk(hclk), .hresetn(hresetn), .host_xfer_go(host_xfer_go),
        .sectors(nsec), .host_sector_done(host_sector_done));

    // Clock generator
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // Event counters seen at the ports
    always @(posedge hclk) begin
        if (host_sector_done === 1'b1) sec_seen++;
        if (host_xfer_go === 1'b1) go_count++;
        if (media_go === 1'b1 && media_is_write === 1'b1) wr_count++;
        if (irq === 1'b1 && first_irq == 0) first_irq = sec_seen;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One single AHB transfer; hrdata stands until the next read is taken
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask

    // Task file then command, then poll busy with a bound
    task automatic cmd(input logic [31:0] t, input logic [31:0] c);
        bus(1'b1, OFS_TASK, t);
        bus(1'b1, OFS_CMD, c);
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 80; i++) begin
            bus(1'b0, OFS_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        chk("busy", 32'h0, {31'h0, rd[0]});
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        #500000;
        err_total++;
        end_sim();
    end

    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, host_io_read, csel} = 5'h0;
        {media_sector_read, media_write_done, buffer_full} = 3'h0;
        {htrans, haddr, hwdata, hsize} = {2'h0, 64'h0, 3'h2};
        {master_slave_jumper, cylinder_limit_jumper, nsec} = 11'h401;
        rows = '{'{OFS_CTRL, CTRL_RESET}, '{OFS_GEOM, 32'h3f10_3f96},
                 '{OFS_IDENT_CYL, 32'h0000_3f96}, '{OFS_IRQ_STAT, 32'h0},
                 '{8'h40, 32'h0}};
        tf = '{32'h0000_0000, 32'h003f_9601, 32'h0f3f_953f};
        st = '{32'h4, 32'h4, 32'h1};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            rchk("reset value", rows[i].ofs, rows[i].exp);
        end
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, OFS_CTRL, CTRL_RESET | 32'(k[1]));
            master_slave_jumper <= k[0];
            csel <= k[0];
            repeat (4) @(posedge hclk);
            chk("device_id", 32'(k[1] ? k[0] : !k[0]),
                32'(device_id));
        end
        bus(1'b1, OFS_CTRL, CTRL_RESET);
        master_slave_jumper <= 1'b1;
        bus(1'b1, OFS_IRQ_MASK, 32'hf);
        $display("test identity done");
        // Command for the other drive must be ignored here
        bus(1'b1, OFS_TASK, 32'h1000_0001);
        bus(1'b1, OFS_CMD, 32'h0000_0102);
        host_io_read <= 1'b1;
        repeat (6) @(posedge hclk);
        chk("data_bus_oe", 32'h0, 32'(data_bus_oe));
        chk("go_count", 32'h0, 32'(go_count));
        rchk("irq_stat", OFS_IRQ_STAT, 32'h0);
        bus(1'b1, OFS_TASK, 32'h0000_0001);
        repeat (4) @(posedge hclk);
        chk("data_bus_oe", 32'h1, 32'(data_bus_oe));
        host_io_read <= 1'b0;
        $display("test selection done");
        bus(1'b1, OFS_GEOM, 32'h2008_0064);
        cmd(32'h0100_0302, 32'h0000_0102);
        rchk("lba", OFS_LBA, 32'h0000_0321);
        rchk("irq_stat", OFS_IRQ_STAT, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        chk("writes", 32'h1, 32'(wr_count));
        bus(1'b1, OFS_IRQ_STAT, 32'h1);
        // The clear lands on the edge that ends the bus call
        @(posedge hclk);
        chk("irq", 32'h0, 32'(irq));
        bus(1'b1, OFS_GEOM, 32'h3f10_3f97);
        rchk("geom", OFS_GEOM, 32'h2008_0064);
        rchk("irq_stat", OFS_IRQ_STAT, 32'h8);
        bus(1'b1, OFS_IRQ_STAT, 32'hf);
        $display("test geometry done");
        bus(1'b1, OFS_GEOM, 32'h3f10_3f96);
        for (int i = 0; i < 3; i++) begin
            wr_count = 0;
            cmd(tf[i], 32'h0000_0102);
            rchk("irq_stat", OFS_IRQ_STAT, st[i]);
            chk("writes", {31'h0, st[i][0]}, 32'(wr_count));
            bus(1'b1, OFS_IRQ_STAT, 32'hf);
        end
        $display("test capacity done");
        bus(1'b1, OFS_CTRL, 32'h0000_020e);
        bus(1'b1, OFS_IRQ_MASK, 32'h2);
        {nsec, sec_seen, first_irq} = {9'h004, 32'h0, 32'h0};
        cmd(32'h0000_0001, 32'h0000_0402);
        chk("sectors", 32'h4, 32'(sec_seen));
        chk("block irq at", 32'h2, 32'(first_irq));
        bus(1'b1, OFS_IRQ_STAT, 32'hf);
        $display("test multiple done");
        // Read miss pushed past a defect, then a hit inside read-ahead
        bus(1'b1, OFS_CTRL, CTRL_RESET);
        bus(1'b1, OFS_DEFECT, 32'h8000_0005);
        nsec <= 9'h001;
        media_sector_read <= 1'b1;
        cmd(32'h0000_0008, 32'h0000_0101);
        rchk("phys", OFS_PHYS, 32'h0000_0008);
        chk("media_phys", 32'h8, media_phys);
        cmd(32'h0000_0009, 32'h0000_0101);
        rchk("lba", OFS_LBA, 32'h0000_0008);
        chk("media_phys", 32'h8, media_phys);
        rchk("status", OFS_STATUS, 32'h0000_0312);
        media_sector_read <= 1'b0;
        bus(1'b1, OFS_IRQ_STAT, 32'hf);
        $display("test read-ahead done");
        // A full buffer holds a cached write back until it drains
        buffer_full <= 1'b1;
        bus(1'b1, OFS_TASK, 32'h0000_0001);
        bus(1'b1, OFS_CMD, 32'h0000_0102);
        repeat (8) @(posedge hclk);
        rchk("status", OFS_STATUS, 32'h0000_030b);
        buffer_full <= 1'b0;
        cmd(32'h0000_0001, 32'h0000_0000);
        rchk("irq_stat", OFS_IRQ_STAT, 32'h1);
        bus(1'b1, OFS_IRQ_STAT, 32'hf);
        // Without the cache a write ends only when the media is done
        bus(1'b1, OFS_CTRL, 32'h0000_0100);
        media_write_done <= 1'b1;
        cmd(32'h0000_0001, 32'h0000_0102);
        media_write_done <= 1'b0;
        rchk("irq_stat", OFS_IRQ_STAT, 32'h1);
        rchk("status", OFS_STATUS, 32'h0000_0002);
        $display("test write stack done");
        cylinder_limit_jumper <= 1'b1;
        repeat (4) @(posedge hclk);
        rchk("ident_cyl", OFS_IDENT_CYL, 32'h0000_0ffc);
        rchk("geom", OFS_GEOM, 32'h3f10_3f96);
        $display("test cylinder limit done");
        end_sim();
    end
endmodule
